// file: hw/alpi_ctrl.sv
// alarm and power-fail interrupt control with main status byte,
// axi4-lite slave; assumes counters and ticks come from logic on aclk,
// power-fail and standby inputs are asynchronous pins
`include "alpi_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module alpi_ctrl
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // counter chain side
    input wire alpi_pkg::alpi_time_t time_counters,
    input wire logic time_update,
    input wire logic [5:0] periodic_tick,
    // pins
    input wire logic power_fail_input_n,
    input wire logic standby_active,
    output logic interrupt_output_pin_n,
    output logic multi_function_output_n,
    output logic register_block_select,
    output logic irq
);
    import alpi_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] enable_reg;
    logic [7:0] period_reg;
    logic [7:0] mode_reg;
    logic [7:0] status_ram;
    logic [3:0] mask_reg;
    logic [7:0] cmp_ram [6];
    logic st_pf;
    logic st_per;
    logic st_alm;
    logic pf_s1, pf_s2;
    logic sb_s1, sb_s2, sb_d;
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic wr_byte;
    logic [7:0] wb;
    logic alarm_match;
    logic sb_enter;
    logic sb_lock;
    alpi_time_t cmp_bytes;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic is_cmp(input logic [11:0] a);
        return a >= `ALPI_OFS_CMP0 && a <= `ALPI_OFS_CMP5 && a[1:0] == 2'b00;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return is_cmp(a) || a == `ALPI_OFS_STATUS || a == `ALPI_OFS_ENABLE
            || a == `ALPI_OFS_PERIOD || a == `ALPI_OFS_MODE
            || a == `ALPI_OFS_MASK;
    endfunction

    function automatic logic [2:0] cmp_idx(input logic [11:0] a);
        logic [11:0] d;
        d = a - `ALPI_OFS_CMP0;
        return d[4:2];
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pf_s1 <= 1'b1;
            pf_s2 <= 1'b1;
            sb_s1 <= 1'b0;
            sb_s2 <= 1'b0;
            sb_d <= 1'b0;
        end
        else
        begin
            pf_s1 <= power_fail_input_n;
            pf_s2 <= pf_s1;
            sb_s1 <= standby_active;
            sb_s2 <= sb_s1;
            sb_d <= sb_s2;
        end
    end

    assign sb_enter = sb_s2 && !sb_d;
    // without standby enable the alarm, power-fail and periodic enables stay cleared for all of standby
    assign sb_lock = sb_s2 && !mode_reg[`ALPI_MODE_SIE];

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign wr_byte = wr_go && w_strb[0] && is_mapped(aw_addr);
    assign wb = w_data[7:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ALPI_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(aw_addr) ? `ALPI_RESP_OKAY
                                                  : `ALPI_RESP_SLVERR;
            end
            // one write at a time: channels reopen after the response
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_reg <= `ALPI_RST_BYTE;
            period_reg <= `ALPI_RST_BYTE;
            mode_reg <= `ALPI_RST_BYTE;
            status_ram <= `ALPI_RST_BYTE;
            mask_reg <= `ALPI_RST_MASK;
        end
        else
        begin
            if (wr_byte)
            begin
                unique case (aw_addr)
                    `ALPI_OFS_ENABLE: enable_reg <= wb;
                    `ALPI_OFS_PERIOD: period_reg <= wb;
                    `ALPI_OFS_MODE: mode_reg <= wb;
                    `ALPI_OFS_MASK: mask_reg <= wb[3:0];
                    `ALPI_OFS_STATUS: status_ram <= {wb[7:4], 4'h0};
                    default: ;
                endcase
            end
            if (sb_enter && !mode_reg[`ALPI_MODE_SIE] || sb_lock)
            begin
                period_reg[5:0] <= 6'h00;
                enable_reg[`ALPI_EN_ALM] <= 1'b0;
                enable_reg[`ALPI_EN_PF] <= 1'b0;
            end
        end
    end

    // compare bytes stay plain storage whatever the enables say
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < 6; i++)
            begin
                cmp_ram[i] <= `ALPI_RST_BYTE;
            end
        end
        else if (wr_byte && is_cmp(aw_addr))
        begin
            cmp_ram[cmp_idx(aw_addr)] <= wb;
        end
    end

    assign cmp_bytes = {cmp_ram[5], cmp_ram[4], cmp_ram[3],
                        cmp_ram[2], cmp_ram[1], cmp_ram[0]};

    alpi_cmp #(
        .N(6)
    ) u_cmp (
        .counters(time_counters),
        .compare(cmp_bytes),
        .enable(enable_reg[5:0]),
        .all_equal(alarm_match)
    );

    // ------------------------------------------------------------
    // status bits; set wins over a one written in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_alm <= 1'b0;
            st_per <= 1'b0;
            st_pf <= 1'b0;
        end
        else
        begin
            if (time_update && alarm_match && |enable_reg[5:0])
            begin
                st_alm <= 1'b1;
            end
            else if (wr_byte && aw_addr == `ALPI_OFS_STATUS && wb[`ALPI_ST_ALM])
            begin
                st_alm <= 1'b0;
            end
            if (|(periodic_tick & period_reg[5:0]))
            begin
                st_per <= 1'b1;
            end
            else if (wr_byte && aw_addr == `ALPI_OFS_STATUS && wb[`ALPI_ST_PER])
            begin
                st_per <= 1'b0;
            end
            // follows the pin, software writes have no effect
            st_pf <= !pf_s2;
        end
    end

    // ------------------------------------------------------------
    // pins and interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            interrupt_output_pin_n <= 1'b1;
            multi_function_output_n <= 1'b1;
            register_block_select <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            interrupt_output_pin_n <= !(st_alm && enable_reg[`ALPI_EN_ALM]
                || st_per && |period_reg[5:0]);
            multi_function_output_n <= !(st_pf
                && enable_reg[`ALPI_EN_PF]);
            register_block_select <= status_ram[6];
            irq <= |({st_alm, st_per, st_pf} & mask_reg[3:1]);
        end
    end

    // ------------------------------------------------------------
    // axi read channel; reads have no side effects
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ALPI_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? `ALPI_RESP_OKAY
                                                   : `ALPI_RESP_SLVERR;
            s_axi_rdata <= 32'h0000_0000;
            if (is_cmp(s_axi_araddr))
            begin
                s_axi_rdata[7:0] <= cmp_ram[cmp_idx(s_axi_araddr)];
            end
            else
            begin
                unique case (s_axi_araddr)
                    `ALPI_OFS_STATUS: s_axi_rdata[7:0] <= {status_ram[7:4],
                        st_alm, st_per, st_pf,
                        !interrupt_output_pin_n
                        || !multi_function_output_n};
                    `ALPI_OFS_ENABLE: s_axi_rdata[7:0] <= enable_reg;
                    `ALPI_OFS_PERIOD: s_axi_rdata[7:0] <= period_reg;
                    `ALPI_OFS_MODE: s_axi_rdata[7:0] <= mode_reg;
                    `ALPI_OFS_MASK: s_axi_rdata[3:0] <= mask_reg;
                    default: ;
                endcase
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    cmp_enable_a: assert property (
        enable_reg[0] && time_counters.c0 != cmp_ram[0] |-> !alarm_match)
        else $error("enabled mismatching comparator reported equal");
    cmp_disable_a: assert property (
        enable_reg[5:0] == 6'h00 |-> alarm_match)
        else $error("disabled comparators not always equal");
    alarm_pin_a: assert property (
        !enable_reg[`ALPI_EN_ALM] && !st_per |=> interrupt_output_pin_n)
        else $error("interrupt pin low without alarm enable");
    pf_pin_a: assert property (
        st_pf && enable_reg[`ALPI_EN_PF] |=> !multi_function_output_n)
        else $error("power fail interrupt not signalled");
    standby_hold_a: assert property (
        sb_lock |=> !enable_reg[`ALPI_EN_ALM] && !enable_reg[`ALPI_EN_PF])
        else $error("enables alive in standby without standby enable");
    alarm_set_a: assert property (
        time_update && alarm_match && |enable_reg[5:0] |=> st_alm)
        else $error("alarm status not set on match");
    alarm_sticky_a: assert property (
        st_alm && !(wr_byte && aw_addr == `ALPI_OFS_STATUS) |=> st_alm)
        else $error("alarm status lost without a write");
    pf_follow_a: assert property (
        pf_s2 |=> !st_pf)
        else $error("power fail status not cleared by high pin");
    summary_bit_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `ALPI_OFS_STATUS
        && !interrupt_output_pin_n |=> s_axi_rdata[`ALPI_ST_SUM])
        else $error("summary bit low with pin pending");
    standby_clear_a: assert property (
        sb_enter && !mode_reg[`ALPI_MODE_SIE] |=> period_reg[5:0] == 6'h00)
        else $error("periodic enables survive standby entry");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

    alarm_seen_c: cover property (st_alm && !interrupt_output_pin_n);
    pf_seen_c: cover property (!multi_function_output_n ##[1:20] irq);
    standby_c: cover property (sb_enter ##1 sb_lock);
    w1c_c: cover property (st_alm ##1 !st_alm);

endmodule

`default_nettype wire

// file: hw/alpi_defines.svh
// register offsets, field positions and reset values of the alarm and
// power-fail interrupt block; assumes a 32-bit aligned register map
`ifndef ALPI_DEFINES_SVH
`define ALPI_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ALPI_OFS_STATUS 12'h000
`define ALPI_OFS_ENABLE 12'h004
`define ALPI_OFS_PERIOD 12'h008
`define ALPI_OFS_MODE 12'h00C
`define ALPI_OFS_MASK 12'h010
`define ALPI_OFS_CMP0 12'h020
`define ALPI_OFS_CMP5 12'h034

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ALPI_ST_SUM 0
`define ALPI_ST_PF 1
`define ALPI_ST_PER 2
`define ALPI_ST_ALM 3
`define ALPI_EN_ALM 6
`define ALPI_EN_PF 7
`define ALPI_MODE_SIE 4

// ------------------------------------------------------------
// reset values and bus answers
// ------------------------------------------------------------
`define ALPI_RST_BYTE 8'h00
`define ALPI_RST_MASK 4'h0
`define ALPI_RESP_OKAY 2'b00
`define ALPI_RESP_SLVERR 2'b10

`endif

// file: hw/alpi_pkg.sv
// types shared by the alarm and power-fail interrupt block
// assumes the defines header is compiled alongside
package alpi_pkg;

    // ------------------------------------------------------------
    // six time counters or six compare bytes, one byte each
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] c5;
        logic [7:0] c4;
        logic [7:0] c3;
        logic [7:0] c2;
        logic [7:0] c1;
        logic [7:0] c0;
    } alpi_time_t;

endpackage

// file: hw/alpi_cmp.sv
// bank of six counter-to-compare-byte comparators
// assumes counters and compare bytes live in the same clock domain
`timescale 1ns/10ps
`default_nettype none

module alpi_cmp
    import alpi_pkg::*;
#(
    parameter int N = 6
)
(
    // operands
    input wire alpi_pkg::alpi_time_t counters,
    input wire alpi_pkg::alpi_time_t compare,
    input wire logic [N-1:0] enable,
    // result
    output logic all_equal
);
    logic [8*N-1:0] cnt;
    logic [8*N-1:0] cmp;
    logic [N-1:0] eq;

    assign cnt = counters;
    assign cmp = compare;

    // a disabled comparator always reports equal
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            eq[i] = !enable[i] || (cnt[8*i +: 8] == cmp[8*i +: 8]);
        end
    end

    assign all_equal = &eq;

endmodule

`default_nettype wire

// file: test/alpi_host.sv
// host model: axi4-lite master, one write and one read at a time
// assumes the bench calls its tasks and the slave runs on aclk
`timescale 1ns/10ps
`default_nettype none

module alpi_host
(
    // clock
    input wire logic aclk,
    // write channels
    output var logic [11:0] s_axi_awaddr,
    output var logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output var logic [31:0] s_axi_wdata,
    output var logic [3:0] s_axi_wstrb,
    output var logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output var logic s_axi_bready,
    // read channels
    output var logic [11:0] s_axi_araddr,
    output var logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output var logic s_axi_rready
);
    initial
    begin
        s_axi_awaddr = 12'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 12'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // released lines get the inverse so a stale value never looks valid
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
        output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wready)
                {s_axi_wvalid, s_axi_wdata} <= {1'b0, 24'h00_0000, ~d};
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
endmodule

`default_nettype wire

// file: test/alpi_tb_top.sv
// bench for the alarm and power-fail interrupt block
// assumes the host model carries every register transfer
`include "alpi_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module alarm_powerfail_interrupt_control_tb_top
    import alpi_pkg::*;
;
    localparam logic [11:0] ST = `ALPI_OFS_STATUS;
    localparam logic [11:0] EN = `ALPI_OFS_ENABLE;
    localparam logic [11:0] PE = `ALPI_OFS_PERIOD;
    localparam logic [11:0] MD = `ALPI_OFS_MODE;
    localparam logic [11:0] MK = `ALPI_OFS_MASK;
    localparam logic [11:0] CM = `ALPI_OFS_CMP0;
    logic aclk, aresetn, time_update, power_fail_input_n, standby_active;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, irq, register_block_select;
    logic interrupt_output_pin_n, multi_function_output_n;
    logic [5:0] periodic_tick;
    alpi_time_t time_counters;
    logic [63:0] rnd;
    logic [33:0] exp_q[$];
    int seed, mismatches, n_tests, i, k;

    alpi_ctrl u_dut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .time_counters, .time_update,
        .periodic_tick, .power_fail_input_n, .standby_active,
        .interrupt_output_pin_n, .multi_function_output_n,
        .register_block_select, .irq
    );

    alpi_host u_host
    (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rvalid, .s_axi_rready
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic rdx(input logic [11:0] a, input logic [7:0] d);
        exp_q.push_back({2'b00, 24'h00_0000, d});
        u_host.rd(a);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        u_host.wr(a, d, r);
    endtask

    task automatic pin(input logic s, input logic e);
        check({33'h0, s}, {33'h0, e});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic tick_time();
        @(posedge aclk) time_update <= 1'b1;
        @(posedge aclk) time_update <= 1'b0;
        cyc(3);
    endtask

    // read data checked in order against the notes left by the driver
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end

    initial
    begin
        repeat (4000) @(posedge aclk);
        mismatches++;
        conclude();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        seed = 30774;
        mismatches = 0;
        n_tests = 0;
        aresetn = 1'b0;
        time_update = 1'b0;
        periodic_tick = 6'h00;
        power_fail_input_n = 1'b1;
        standby_active = 1'b0;
        time_counters = '0;
        cyc(3);
        aresetn <= 1'b1;
        rdx(ST, 8'h00);
        rdx(EN, 8'h00);
        wr(12'h0FC, 8'hFF);
        check({32'h0000_0000, r}, {32'h0000_0000, 2'b10});
        exp_q.push_back({2'b10, 32'h0000_0000});
        u_host.rd(12'h0FC);
        $display("test reset done");
        rnd = {$random(seed), $random(seed)};
        time_counters <= rnd[47:0];
        for (i = 0; i < 6; i++)
            wr(CM + 12'(4 * i), rnd[8 * i +: 8]);
        wr(MK, 8'h08);
        wr(EN, 8'h3F);
        tick_time();
        rdx(ST, 8'h08);
        pin(interrupt_output_pin_n, 1'b1);
        pin(irq, 1'b1);
        wr(EN, 8'h7F);
        cyc(3);
        pin(interrupt_output_pin_n, 1'b0);
        rdx(ST, 8'h09);
        rdx(ST, 8'h09);
        wr(ST, 8'h0F);
        cyc(3);
        rdx(ST, 8'h00);
        pin(interrupt_output_pin_n, 1'b1);
        pin(irq, 1'b0);
        // one counter off by a bit: the full compare must miss
        time_counters <= rnd[47:0] ^ 48'h0000_0001_0000;
        tick_time();
        rdx(ST, 8'h00);
        wr(EN, 8'h41);
        tick_time();
        rdx(ST, 8'h09);
        rdx(CM + 12'h008, rnd[23:16]);
        wr(ST, 8'h08);
        wr(EN, 8'h00);
        tick_time();
        rdx(ST, 8'h00);
        $display("test alarm done");
        k = $unsigned($random(seed)) % 6;
        wr(PE, 8'h3F);
        @(posedge aclk) periodic_tick <= 6'(1 << k);
        @(posedge aclk) periodic_tick <= 6'h00;
        cyc(3);
        rdx(ST, 8'h05);
        pin(interrupt_output_pin_n, 1'b0);
        wr(ST, 8'h04);
        cyc(3);
        rdx(ST, 8'h00);
        $display("test periodic done");
        wr(MK, 8'h0E);
        wr(EN, 8'h80);
        power_fail_input_n <= 1'b0;
        cyc(6);
        pin(multi_function_output_n, 1'b0);
        pin(irq, 1'b1);
        rdx(ST, 8'h03);
        wr(ST, 8'h02);
        rdx(ST, 8'h03);
        power_fail_input_n <= 1'b1;
        cyc(6);
        rdx(ST, 8'h00);
        pin(multi_function_output_n, 1'b1);
        pin(irq, 1'b0);
        // summary bit cannot be written; bit 6 drives the block select pin
        wr(ST, 8'h41);
        rdx(ST, 8'h40);
        pin(register_block_select, 1'b1);
        $display("test power fail done");
        wr(EN, 8'hC0);
        wr(MD, 8'h10);
        standby_active <= 1'b1;
        cyc(6);
        rdx(EN, 8'hC0);
        rdx(PE, 8'h3F);
        standby_active <= 1'b0;
        wr(MD, 8'h00);
        standby_active <= 1'b1;
        cyc(6);
        rdx(EN, 8'h00);
        rdx(PE, 8'h00);
        wr(EN, 8'hC0);
        rdx(EN, 8'h00);
        standby_active <= 1'b0;
        $display("test standby done");
        // let the monitor take the last answer before the verdict
        cyc(2);
        check(34'(exp_q.size()), 34'h0);
        conclude();
    end
endmodule

`default_nettype wire
